// File: hdl/gpio_expander.v
// How it works
// RULE1: pins come in groups of eight, each chip one direction.
// RULE2: chain holds at most eight chips, sixty-four pins total.
// RULE3: chain reset held low until run bit is one.
// RULE4: load strobe held low until run bit is one.
// RULE5: shift clock static until run bit is one.
// RULE6: data out, strobe, reset, clock driven; data in sampled.
// RULE7: one bit per shift clock; one strobe per full chain transfer.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_expander_consts.vh"
module gpio_expander #(
  parameter OUT_CHIPS = 2, // output chips in chain
  parameter IN_CHIPS = 2 // input chips in chain
) (
  input wire clk, // 20 MHz system clock
  input wire rst, // synchronous reset, active high
  input wire controller_run_bit, // software run bit
  input wire [`MAX_PINS-1:0] out_pins, // values for expanded outputs
  output reg [`MAX_PINS-1:0] in_pins, // captured expanded inputs
  output reg frame_done, // one-cycle pulse per full transfer
  output reg expander_serial_out, // serial data to chain
  output reg expander_load_strobe, // latch/capture strobe
  input wire expander_serial_in, // serial data from chain
  output reg expander_chain_reset_n, // chain reset, active low
  output reg expander_shift_clock // shift clock to chain
);
  localparam OUT_BITS = OUT_CHIPS * `PINS_PER_CHIP; // RULE1
  localparam IN_BITS = IN_CHIPS * `PINS_PER_CHIP; // RULE1
  localparam RAW_LEN = (OUT_BITS > IN_BITS) ? OUT_BITS : IN_BITS;
  localparam LEN = (RAW_LEN > `MAX_PINS) ? `MAX_PINS : RAW_LEN; // RULE2
  localparam HALF = (`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam S_IDLE = 3'h1;
  localparam S_SHIFT = 3'h2;
  localparam S_LOAD = 3'h4;

  // frame sequencing
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [`CHAIN_CNT_W-1:0] bit_q;
  reg [`CHAIN_CNT_W-1:0] bit_d;

  // outgoing and incoming shift words
  reg [`MAX_PINS-1:0] tx_q;
  reg [`MAX_PINS-1:0] tx_d;
  reg [`MAX_PINS-1:0] rx_q;
  reg [`MAX_PINS-1:0] rx_d;
  reg [`MAX_PINS-1:0] in_pins_d;
  reg frame_done_d;

  // next values of the chain pins
  reg serial_out_d;
  reg load_strobe_d;
  reg chain_reset_n_d;
  reg shift_clock_d;

  // serial input synchroniser and delayed run bit
  reg din_s1_q;
  reg din_s2_q;
  reg run_q;

  wire tick;
  wire start_frame;
  wire last_bit;
  wire sclk_low;

  // moves a word up one place and fills the freed low bit
  function [`MAX_PINS-1:0] shift_up;
    input [`MAX_PINS-1:0] word;
    input fill;
    begin
      shift_up = {word[`MAX_PINS-2:0], fill};
    end
  endfunction

  // run must be seen on two edges, so the chain leaves reset before the first shift
  assign start_frame = controller_run_bit && run_q; // RULE3
  assign last_bit = (bit_q == LEN[`CHAIN_CNT_W-1:0] - 1'h1); // RULE1 RULE2
  assign sclk_low = !expander_shift_clock;

  // half-period enable; stopped while the run bit is low
  shift_clock_divider #(.HALF_CYCLES(HALF)) u_div (
    .clk(clk),
    .rst(rst),
    .run(run_q),
    .tick(tick)
  );

  // two-flop synchroniser on the serial input
  always @(posedge clk) begin
    din_s1_q <= expander_serial_in; // RULE6
    din_s2_q <= din_s1_q;
  end

  always @(posedge clk) begin
    if (rst) begin
      run_q <= 1'h0;
    end else begin
      run_q <= controller_run_bit;
    end
  end

  always @* begin
    state_d = state_q;
    bit_d = bit_q;
    tx_d = tx_q;
    rx_d = rx_q;
    in_pins_d = in_pins;
    frame_done_d = 1'h0;
    serial_out_d = expander_serial_out;
    load_strobe_d = expander_load_strobe;
    chain_reset_n_d = expander_chain_reset_n;
    shift_clock_d = expander_shift_clock;
    case (state_q)
      S_IDLE: begin
        shift_clock_d = `SCLK_IDLE; // RULE5
        load_strobe_d = `STROBE_LOW; // RULE4
        chain_reset_n_d = controller_run_bit; // RULE3
        if (start_frame) begin
          tx_d = out_pins;
          bit_d = {`CHAIN_CNT_W{1'h0}};
          serial_out_d = out_pins[LEN-1]; // RULE6
          state_d = S_SHIFT;
        end
      end
      S_SHIFT: begin
        if (!controller_run_bit) begin
          // abort: park the clock low and put the chain back in reset
          shift_clock_d = `SCLK_IDLE; // RULE5
          chain_reset_n_d = `CHAIN_RESET_ACTIVE; // RULE3
          state_d = S_IDLE;
        end else if (tick) begin
          shift_clock_d = ~expander_shift_clock; // RULE7
          if (sclk_low) begin
            // the chain shifts on this rise, so take the bit it showed before it
            rx_d = shift_up(rx_q, din_s2_q); // RULE6
          end else begin
            // new data settles a full half period ahead of the next rise
            tx_d = shift_up(tx_q, 1'h0);
            serial_out_d = tx_q[LEN-2]; // RULE7
            if (last_bit) begin
              load_strobe_d = 1'h1; // RULE7
              state_d = S_LOAD;
            end else begin
              bit_d = bit_q + 1'h1;
            end
          end
        end
      end
      S_LOAD: begin
        // strobe stands one half period, then the captured word is handed over
        if (tick) begin
          load_strobe_d = `STROBE_LOW;
          in_pins_d = rx_q;
          frame_done_d = 1'h1;
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      bit_q <= {`CHAIN_CNT_W{1'h0}};
    end else begin
      state_q <= state_d;
      bit_q <= bit_d;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      tx_q <= {`MAX_PINS{1'h0}};
      rx_q <= {`MAX_PINS{1'h0}};
    end else begin
      tx_q <= tx_d;
      rx_q <= rx_d;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      in_pins <= {`MAX_PINS{1'h0}};
      frame_done <= 1'h0;
    end else begin
      in_pins <= in_pins_d;
      frame_done <= frame_done_d;
    end
  end

  // chain pins stay quiet from reset until the run bit arrives
  always @(posedge clk) begin
    if (rst) begin
      expander_serial_out <= 1'h0;
    end else begin
      expander_serial_out <= serial_out_d; // RULE6
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      expander_load_strobe <= `STROBE_LOW; // RULE4
    end else begin
      expander_load_strobe <= load_strobe_d;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      expander_chain_reset_n <= `CHAIN_RESET_ACTIVE; // RULE3
    end else begin
      expander_chain_reset_n <= chain_reset_n_d;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      expander_shift_clock <= `SCLK_IDLE; // RULE5
    end else begin
      expander_shift_clock <= shift_clock_d;
    end
  end
endmodule
`default_nettype wire

// File: hdl/gpio_expander_consts.vh
`ifndef GPIO_EXPANDER_CONSTS_VH
`define GPIO_EXPANDER_CONSTS_VH
`define PINS_PER_CHIP 8
`define MAX_CHIPS 8
`define MAX_PINS 64
`define CHAIN_CNT_W 7
`define SCLK_HALF_NS 200
`define CLK_PERIOD_NS 50
`define STROBE_LOW 1'h0
`define CHAIN_RESET_ACTIVE 1'h0
`define SCLK_IDLE 1'h0
`endif

// File: hdl/shift_clock_divider.v
`timescale 1ns/1ps
`default_nettype none
`include "gpio_expander_consts.vh"
module shift_clock_divider #(
  parameter HALF_CYCLES = 4
) (
  input wire clk, // system clock
  input wire rst, // synchronous reset
  input wire run, // enables counting
  output reg tick // one-cycle pulse every half shift period
);
  reg [15:0] cnt_q;
  always @(posedge clk) begin
    if (rst || !run) begin
      cnt_q <= 16'h0000;
      tick <= 1'h0;
    end else if (cnt_q == HALF_CYCLES[15:0] - 16'h0001) begin
      cnt_q <= 16'h0000;
      tick <= 1'h1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick <= 1'h0;
    end
  end
endmodule
`default_nettype wire

// File: verification/gpio_expander_properties.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_expander_properties #(
  parameter OUT_CHIPS = 2,
  parameter IN_CHIPS = 2
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic controller_run_bit, // run bit
  input wire logic expander_load_strobe, // load strobe pin
  input wire logic expander_chain_reset_n, // chain reset pin
  input wire logic expander_shift_clock, // shift clock pin
  input wire logic expander_serial_out // serial data pin
);
  localparam LEN = 8 * (OUT_CHIPS > IN_CHIPS ? OUT_CHIPS : IN_CHIPS);
  wire r = controller_run_bit, l = expander_load_strobe, c = expander_shift_clock;
  reg [6:0] n_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // shift clock rises since the last strobe
  always @(posedge clk) n_q <= (rst || !r || l) ? 7'h00 : n_q + $rose(c);
  chk_chain_held: assert property (!r [*3] |-> !expander_chain_reset_n) else $error("rst");
  chk_strobe_idle: assert property (!r [*3] |-> !l) else $error("strobe idle");
  chk_clock_idle: assert property (!r [*3] |-> $stable(c)) else $error("clock idle");
  chk_data_edge: assert property ($changed(expander_serial_out) |-> !c) else $error("dout");
  chk_frame_bits: assert property ($rose(l) |-> n_q == LEN) else $error("bit count");
  chk_clock_half: assert property ($fell(c) && $past(r) |-> $past(c, 4) && !$past(c, 5))
    else $error("clock width");
  chk_strobe_len: assert property ($fell(l) && $past(r) |-> $past(l, 4) && !$past(l, 5))
    else $error("strobe width");
  cover property ($rose(l));
  cover property ($fell(r) && c);
  cover property ($rose(expander_chain_reset_n));
endmodule
bind gpio_expander gpio_expander_properties #(
  .OUT_CHIPS(OUT_CHIPS),
  .IN_CHIPS(IN_CHIPS)
) u_chk (
  .clk(clk),
  .rst(rst),
  .controller_run_bit(controller_run_bit),
  .expander_load_strobe(expander_load_strobe),
  .expander_chain_reset_n(expander_chain_reset_n),
  .expander_shift_clock(expander_shift_clock),
  .expander_serial_out(expander_serial_out)
);
`default_nettype wire

// File: verification/shift_chain.sv
`timescale 1ns/1ps
`default_nettype none
// two output chips and two input chips on separate shift paths, eight pins each
module shift_chain (
  input wire logic expander_shift_clock, // shift clock
  input wire logic expander_load_strobe, // latch and capture strobe
  input wire logic expander_chain_reset_n, // chain reset, active low
  input wire logic expander_serial_out, // data from the controller
  input wire logic [15:0] par_in, // parallel inputs
  output logic expander_serial_in, // data to the controller
  output logic [15:0] par_out // latched outputs
);
  logic [15:0] so, si;
  assign expander_serial_in = si[15];
  always @(posedge expander_shift_clock or posedge expander_load_strobe
      or negedge expander_chain_reset_n)
    if (!expander_chain_reset_n) {par_out, so, si} <= 48'h0;
    else if (expander_load_strobe) {par_out, si} <= {so, par_in};
    else {so, si} <= {so[14:0], expander_serial_out, si[14:0], 1'h0};
endmodule
`default_nettype wire

// File: verification/gpio_expander_test.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_expander_test;
  logic clk = 0, rst = 1, controller_run_bit = 0, frame_done, expander_serial_out;
  logic expander_load_strobe, expander_serial_in, expander_chain_reset_n, expander_shift_clock;
  logic [63:0] out_pins, in_pins;
  logic [15:0] par_in = 16'h0000, par_out;
  logic [15:0] exp_o[$], exp_i[$];
  int seed = 49, errors = 0, n_compared = 0, k;
  always #25 clk = ~clk;
  gpio_expander u_gpio_expander (
    .clk(clk),
    .rst(rst),
    .controller_run_bit(controller_run_bit),
    .out_pins(out_pins),
    .in_pins(in_pins),
    .frame_done(frame_done),
    .expander_serial_out(expander_serial_out),
    .expander_load_strobe(expander_load_strobe),
    .expander_serial_in(expander_serial_in),
    .expander_chain_reset_n(expander_chain_reset_n),
    .expander_shift_clock(expander_shift_clock)
  );
  shift_chain u_shift_chain (
    .expander_shift_clock(expander_shift_clock),
    .expander_load_strobe(expander_load_strobe),
    .expander_chain_reset_n(expander_chain_reset_n),
    .expander_serial_out(expander_serial_out),
    .par_in(par_in),
    .expander_serial_in(expander_serial_in),
    .par_out(par_out)
  );
  task chk(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // waits for one frame end, checks both directions, then loads new values
  task frame;
    k = 0;
    do @(negedge clk) k++; while (frame_done !== 1'b1 && k < 400);
    chk(k < 400, 1);
    chk(par_out, exp_o.pop_front());
    chk(in_pins[15:0], exp_i.pop_front());
    exp_i.push_back(par_in);
    out_pins = {$random(seed), $random(seed)};
    par_in = 16'($random(seed));
    exp_o.push_back(out_pins[15:0]);
  endtask
  initial begin
    out_pins = {$random(seed), $random(seed)};
    exp_o = {out_pins[15:0]};
    exp_i = {16'h0000};
    repeat (4) @(negedge clk);
    rst = 0;
    repeat (20) @(negedge clk);
    chk({expander_chain_reset_n, expander_load_strobe, expander_shift_clock}, 0);
    controller_run_bit = 1;
    repeat (6) frame();
    // drop run while the shift clock stands high, mid-frame
    repeat (46) @(negedge clk);
    controller_run_bit = 0;
    repeat (3) @(negedge clk);
    chk({expander_chain_reset_n, expander_shift_clock}, 0);
    exp_o = {out_pins[15:0]};
    exp_i = {16'h0000};
    controller_run_bit = 1;
    frame();
    complete_run();
  end
  initial begin
    #1000000;
    errors++;
    complete_run();
  end
endmodule
`default_nettype wire
